// *** design/prp_device.sv ***
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module prp_device
  import prp_pkg::*;
#(
  parameter int unsigned DR_BASE_CYC = PRP_DR_BASE_CYC,
  parameter int unsigned RESPIRATION_CONFIG_REGISTER_HALF_BASE = PRP_RESPIRATION_CONFIG_REGISTER_HALF_BASE
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  prp_link_if.dev link,
  output logic pace_on_o,
  output logic [2:0] pace_out_odd_pin_o,
  output logic [2:0] pace_out_even_pin_o,
  output logic settled_o,
  output logic respiration_config_register_active_o
);

  typedef struct packed {
    logic [PRP_DW-1:0] rate;
    logic [PRP_DW-1:0] pace;
    logic [PRP_DW-1:0] respiration_config_register;
    logic [PRP_DW-1:0] fourth_setup_register;
    logic [PRP_DW-1:0] gpio;
    logic [PRP_DW-1:0] rdata;
    logic [PRP_CNT_W-1:0] smp_cnt;
    logic [1:0] settle_cnt;
    logic drdy;
    logic [PRP_FRAME_W-1:0] frame;
    logic [PRP_PINS-1:0] pin_s1;
    logic [PRP_PINS-1:0] pin_s2;
    logic [PRP_CNT_W-1:0] respiration_config_register_cnt;
    logic clk_ip;
    logic clk_qp;
    logic clk_xp;
    logic [PRP_PINS-1:0] pin_out;
    logic [PRP_PINS-1:0] pin_oe;
  } prp_dev_s;

  // defaults taken while any reset source is low
  localparam prp_dev_s DEV_RST = '{
    rate: PRP_RATE_RST,
    pace: PRP_PACE_RST,
    respiration_config_register: PRP_RESPIRATION_CONFIG_REGISTER_RST,
    fourth_setup_register: PRP_FOURTH_RST,
    gpio: PRP_GPIO_RST,
    default: '0
  };

  localparam logic [PRP_CNT_W-1:0] DR_BASE = PRP_CNT_W'(DR_BASE_CYC);
  localparam logic [PRP_CNT_W-1:0] RESPIRATION_CONFIG_REGISTER_BASE = PRP_CNT_W'(RESPIRATION_CONFIG_REGISTER_HALF_BASE);

  prp_dev_s r;
  prp_dev_s n;

  logic dev_rst_n;
  logic [2:0] rate_code;
  logic [1:0] respiration_mode_select;
  logic [2:0] respiration_clock_freq;
  logic [2:0] respiration_clock_phase;
  logic respiration_config_register_ext;
  logic settled;
  logic [PRP_CNT_W-1:0] data_period;
  logic [PRP_CNT_W-1:0] respiration_config_register_half;
  logic [PRP_CNT_W-1:0] respiration_config_register_period;
  logic [PRP_CNT_W-1:0] respiration_config_register_shift;
  logic [PRP_CNT_W-1:0] ph_ext;
  logic [PRP_CNT_W-1:0] q_cnt;

  // base period doubled per code step, used for rate and respiration
  function automatic logic [PRP_CNT_W-1:0] prp_scale(
    input logic [PRP_CNT_W-1:0] base,
    input logic [2:0] sh
  );
    prp_scale = base << sh;
  endfunction : prp_scale

  // reset from the pin, the link, or a stopped link clock
  assign dev_rst_n = rst_n_i & link.dev_rst_n & link.clk_run;

  // field decoding
  assign rate_code = r.rate[PRP_RATE_LSB +: 3];
  assign respiration_mode_select =
    r.respiration_config_register[PRP_RESPIRATION_CONFIG_REGISTER_MODE_LSB +: 2];
  assign respiration_clock_phase =
    r.respiration_config_register[PRP_RESPIRATION_CONFIG_REGISTER_PHASE_LSB +: 3];
  assign respiration_clock_freq =
    r.fourth_setup_register[PRP_FOURTH_FREQ_LSB +: 3];
  assign respiration_config_register_ext = (respiration_mode_select == PRP_RESPIRATION_CONFIG_REGISTER_EXT);
  assign settled = (r.settle_cnt == PRP_SETTLE_PERIODS);

  // period lengths; rate codes above the pace limit are host's concern
  assign data_period = prp_scale(DR_BASE, rate_code);
  assign respiration_config_register_half = prp_scale(RESPIRATION_CONFIG_REGISTER_BASE, respiration_clock_freq);
  assign respiration_config_register_period = respiration_config_register_half << 1;

  // phase step is one eighth of a period, 45 degrees per code
  assign ph_ext = {{(PRP_CNT_W-3){1'b0}}, respiration_clock_phase};
  assign respiration_config_register_shift = ph_ext * (respiration_config_register_period >> 3);
  // delayed copy of the counter; wraps instead of going negative
  assign q_cnt = (r.respiration_config_register_cnt >= respiration_config_register_shift) ?
                 (r.respiration_config_register_cnt - respiration_config_register_shift) :
                 (r.respiration_config_register_cnt + respiration_config_register_period - respiration_config_register_shift);

  // next-state logic for the whole device
  always_comb begin
    n = r;
    n.drdy = 1'b0;

    // pins come from outside, two flops before any use
    n.pin_s1 = link.gpio_lvl;
    n.pin_s2 = r.pin_s1;

    // register writes from the host
    if (link.we) begin
      case (link.addr)
        PRP_REG_RATE: n.rate = link.wdata;
        PRP_REG_PACE: n.pace = link.wdata;
        PRP_REG_RESPIRATION_CONFIG_REGISTER: n.respiration_config_register = link.wdata;
        PRP_REG_FOURTH: n.fourth_setup_register = link.wdata;
        PRP_REG_GPIO: n.gpio = link.wdata;
        default: ;
      endcase
    end

    // register reads, answer stands the cycle after the strobe
    if (link.re) begin
      case (link.addr)
        PRP_REG_RATE: n.rdata = r.rate;
        PRP_REG_PACE: n.rdata = r.pace;
        PRP_REG_RESPIRATION_CONFIG_REGISTER: n.rdata = r.respiration_config_register;
        PRP_REG_FOURTH: n.rdata = r.fourth_setup_register;
        PRP_REG_GPIO: n.rdata = {r.pin_s2, r.gpio[PRP_GPIO_DIR_LSB +: 4]};
        default: n.rdata = '0;
      endcase
    end

    // data period: one frame per period with pin state and settle flag
    if (r.smp_cnt >= data_period - 1'b1) begin
      n.smp_cnt = '0;
      n.drdy = 1'b1;
      n.frame = {settled, r.pin_s2};
      if (!settled) begin
        n.settle_cnt = r.settle_cnt + 1'b1;
      end
    end else begin
      n.smp_cnt = r.smp_cnt + 1'b1;
    end

    // a new rate or channel choice acts as a step; filter restarts
    if (link.we && (link.addr == PRP_REG_RATE ||
                    link.addr == PRP_REG_PACE)) begin
      n.settle_cnt = '0;
      n.smp_cnt = '0;
    end

    // respiration counter runs only in external mode
    if (respiration_config_register_ext) begin
      if (r.respiration_config_register_cnt >= respiration_config_register_period - 1'b1) begin
        n.respiration_config_register_cnt = '0;
      end else begin
        n.respiration_config_register_cnt = r.respiration_config_register_cnt + 1'b1;
      end
    end else begin
      n.respiration_config_register_cnt = '0;
    end

    // clocks registered so the pins carry no glitches
    n.clk_ip = respiration_config_register_ext & (r.respiration_config_register_cnt < respiration_config_register_half);
    n.clk_qp = respiration_config_register_ext & (q_cnt < respiration_config_register_half);
    n.clk_xp = n.clk_ip ^ n.clk_qp;

    // pin drivers: direction bit 1 means input
    n.pin_oe = ~r.gpio[PRP_GPIO_DIR_LSB +: PRP_PINS];
    n.pin_out = r.gpio[PRP_GPIO_OUT_LSB +: PRP_PINS];
    if (respiration_config_register_ext) begin
      n.pin_oe[3:1] = 3'h7;
      n.pin_out[1] = n.clk_xp;
      n.pin_out[2] = n.clk_ip;
      n.pin_out[3] = n.clk_qp;
    end
  end

  // state register, synchronous reset to defaults
  always_ff @(posedge mclk_i) begin
    if (!dev_rst_n) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // link outputs
  assign link.rdata = r.rdata;
  assign link.drdy = r.drdy;
  assign link.frame = r.frame;
  assign link.gpio_dev_out = r.pin_out;
  assign link.gpio_dev_oe = r.pin_oe;

  // pace routing; channel numbers are zero based
  assign pace_on_o = r.pace[PRP_PACE_PWR_BIT];
  assign pace_out_odd_pin_o =
    {r.pace[PRP_PACE_ODD_LSB +: 2], 1'b0};
  assign pace_out_even_pin_o =
    {r.pace[PRP_PACE_EVEN_LSB +: 2], 1'b1};

  assign settled_o = settled;
  assign respiration_config_register_active_o = respiration_config_register_ext;

endmodule : prp_device
`default_nettype wire

// *** design/prp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module prp_host
  import prp_pkg::*;
#(
  parameter int unsigned POR_CYC = PRP_POR_CLK,
  parameter int unsigned RST_LOW_CYC = PRP_RST_LOW_CLK
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  prp_link_if.host link,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o,
  input wire logic supply_ok_i,
  input wire logic pace_detect_i,
  output logic ready_o
);

  typedef enum logic [2:0] {
    H_OFF, H_CLKWAIT, H_RST, H_PROG, H_RUN
  } prp_host_e;

  typedef struct packed {
    prp_host_e state;
    logic [16:0] cnt;
    logic [1:0] ctrl;
    logic [4:0][7:0] cfg;
    logic [2:0] idx;
    logic we;
    logic re;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [1:0] pend;
    logic [7:0] peek;
    logic [4:0] frame;
    logic sup_s1;
    logic sup_s2;
    logic pd_s1;
    logic pd_s2;
    logic [3:0] lvl_s1;
    logic [3:0] lvl_s2;
    logic [15:0] rdata;
  } prp_host_s;

  localparam logic [16:0] POR_LAST = 17'(POR_CYC - 1);
  localparam logic [16:0] RST_LAST = 17'(RST_LOW_CYC - 1);

  prp_host_s r;
  prp_host_s n;
  logic [3:0] cfg_off;

  assign cfg_off = addr_i - PRP_H_CFG0;

  always_comb begin
    n = r;
    n.we = 1'b0;
    n.re = 1'b0;
    n.pend = {r.pend[0], 1'b0};
    // outside levels pass two flops first
    n.sup_s1 = supply_ok_i;
    n.sup_s2 = r.sup_s1;
    n.pd_s1 = pace_detect_i;
    n.pd_s2 = r.pd_s1;
    n.lvl_s1 = link.gpio_lvl;
    n.lvl_s2 = r.lvl_s1;
    if (link.drdy) begin
      n.frame = link.frame;
    end
    if (r.pend[1]) begin
      n.peek = link.rdata;
    end

    // user register writes
    if (we_i) begin
      if (addr_i == PRP_H_CTRL) begin
        n.ctrl = wdata_i[1:0];
      end else if (addr_i >= PRP_H_CFG0 &&
                   cfg_off <= {1'b0, PRP_REG_LAST}) begin
        n.cfg[cfg_off[2:0]] = wdata_i[7:0];
        if (r.state == H_RUN) begin
          n.we = 1'b1;
          n.addr = cfg_off[2:0];
          n.wdata = wdata_i[7:0];
        end
      end else if (addr_i == PRP_H_PEEK_REQ && r.state == H_RUN) begin
        n.re = 1'b1;
        n.addr = wdata_i[2:0];
        n.pend[0] = 1'b1;
      end
    end

    // user register reads, one cycle later
    n.rdata = '0;
    if (re_i) begin
      case (addr_i)
        PRP_H_CTRL: n.rdata = {14'h0, r.ctrl};
        PRP_H_STATUS: n.rdata = {7'h0, r.frame, r.sup_s2, r.state};
        PRP_H_PINS: n.rdata = {12'h0, r.lvl_s2};
        PRP_H_PEEK_DATA: n.rdata = {8'h0, r.peek};
        default: begin
          if (addr_i >= PRP_H_CFG0 && cfg_off <= {1'b0, PRP_REG_LAST}) begin
            n.rdata = {8'h0, r.cfg[cfg_off[2:0]]};
          end
        end
      endcase
    end

    // power-up sequencer
    n.cnt = r.cnt + 1'b1;
    case (r.state)
      H_OFF: begin
        n.cnt = '0;
        if (r.sup_s2 && r.ctrl[PRP_CTRL_EN_BIT]) begin
          n.state = H_CLKWAIT;
        end
      end
      H_CLKWAIT: begin
        if (r.cnt == POR_LAST) begin
          n.state = H_RST;
          n.cnt = '0;
        end
      end
      H_RST: begin
        if (r.cnt == RST_LAST) begin
          n.state = H_PROG;
          n.idx = '0;
        end
      end
      H_PROG: begin
        n.we = 1'b1;
        n.addr = r.idx;
        n.wdata = r.cfg[r.idx];
        n.idx = r.idx + 1'b1;
        if (r.idx == PRP_REG_LAST) begin
          n.state = H_RUN;
        end
      end
      H_RUN: ;
      default: n.state = H_OFF;
    endcase
    // losing supply or enable drops everything back to low
    if (!r.sup_s2 || !r.ctrl[PRP_CTRL_EN_BIT]) begin
      n.state = H_OFF;
      n.we = 1'b0;
      n.re = 1'b0;
      // stale address or data would drive an unpowered device
      n.addr = '0;
      n.wdata = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      // copies start at device defaults, so the first program is harmless
      r <= '{state: H_OFF,
             cfg: {PRP_GPIO_RST, PRP_FOURTH_RST, PRP_RESPIRATION_CONFIG_REGISTER_RST,
                   PRP_PACE_RST, PRP_RATE_RST},
             default: '0};
    end else begin
      r <= n;
    end
  end

  // device inputs all low while off; reset low in off and pulse
  assign link.clk_run = (r.state != H_OFF);
  assign link.dev_rst_n = (r.state != H_OFF) && (r.state != H_RST);
  assign link.we = r.we;
  assign link.re = r.re;
  assign link.addr = r.addr;
  assign link.wdata = r.wdata;
  assign link.gpio_far_out = {3'h0, r.pd_s2};
  // pace detect result fed on pin one only once running
  assign link.gpio_far_oe =
    {3'h0, r.ctrl[PRP_CTRL_PACE_IN_BIT] && r.state == H_RUN};
  assign rdata_o = r.rdata;
  assign ready_o = (r.state == H_RUN);

endmodule : prp_host
`default_nettype wire

// *** design/prp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface prp_link_if
  import prp_pkg::*;
;
  // host to device
  logic clk_run;
  logic dev_rst_n;
  logic we;
  logic re;
  logic [PRP_AW-1:0] addr;
  logic [PRP_DW-1:0] wdata;
  // device to host
  logic [PRP_DW-1:0] rdata;
  logic drdy;
  logic [PRP_FRAME_W-1:0] frame;
  // general pins, driven from either end
  logic [PRP_PINS-1:0] gpio_dev_out;
  logic [PRP_PINS-1:0] gpio_dev_oe;
  logic [PRP_PINS-1:0] gpio_far_out;
  logic [PRP_PINS-1:0] gpio_far_oe;
  logic [PRP_PINS-1:0] gpio_lvl;

  // wire level; device wins a clash, undriven pins pull low
  assign gpio_lvl = (gpio_dev_oe & gpio_dev_out) |
                    (~gpio_dev_oe & gpio_far_oe & gpio_far_out);

  modport dev (
    input clk_run, dev_rst_n, we, re, addr, wdata, gpio_lvl,
    output rdata, drdy, frame, gpio_dev_out, gpio_dev_oe
  );
  modport host (
    output clk_run, dev_rst_n, we, re, addr, wdata, gpio_far_out,
    output gpio_far_oe,
    input rdata, drdy, frame, gpio_lvl
  );
endinterface : prp_link_if
`default_nettype wire

// *** design/prp_pkg.sv ***
package prp_pkg;

  // link data widths
  localparam int PRP_DW = 8;
  localparam int PRP_AW = 3;
  localparam int PRP_PINS = 4;
  localparam int PRP_CNT_W = 20;
  localparam int PRP_FRAME_W = 5;

  // device register indices on the link
  localparam logic [2:0] PRP_REG_RATE = 3'h0;
  localparam logic [2:0] PRP_REG_PACE = 3'h1;
  localparam logic [2:0] PRP_REG_RESPIRATION_CONFIG_REGISTER = 3'h2;
  localparam logic [2:0] PRP_REG_FOURTH = 3'h3;
  localparam logic [2:0] PRP_REG_GPIO = 3'h4;
  localparam logic [2:0] PRP_REG_LAST = 3'h4;

  // field positions
  localparam int PRP_RATE_LSB = 0;
  localparam int PRP_PACE_PWR_BIT = 0;
  localparam int PRP_PACE_ODD_LSB = 1;
  localparam int PRP_PACE_EVEN_LSB = 3;
  localparam int PRP_RESPIRATION_CONFIG_REGISTER_MODE_LSB = 0;
  localparam int PRP_RESPIRATION_CONFIG_REGISTER_PHASE_LSB = 2;
  localparam int PRP_FOURTH_FREQ_LSB = 5;
  localparam int PRP_GPIO_DIR_LSB = 0;
  localparam int PRP_GPIO_OUT_LSB = 4;

  // reset values; every pin starts as an input
  localparam logic [7:0] PRP_RATE_RST = 8'h00;
  localparam logic [7:0] PRP_PACE_RST = 8'h00;
  localparam logic [7:0] PRP_RESPIRATION_CONFIG_REGISTER_RST = 8'h00;
  localparam logic [7:0] PRP_FOURTH_RST = 8'h00;
  localparam logic [7:0] PRP_GPIO_RST = 8'h0f;

  // respiration mode codes
  localparam logic [1:0] PRP_RESPIRATION_CONFIG_REGISTER_OFF = 2'h0;
  localparam logic [1:0] PRP_RESPIRATION_CONFIG_REGISTER_EXT = 2'h1;

  // timing: counts in master clock periods, settling in data periods, rates in kHz and ksps
  localparam logic [1:0] PRP_SETTLE_PERIODS = 2'h3;
  localparam int PRP_DR_BASE_CYC = 1250;
  localparam int PRP_RESPIRATION_CONFIG_REGISTER_HALF_BASE = 625;
  localparam int PRP_POR_CLK = 65536;
  localparam int PRP_RST_LOW_CLK = 2;
  localparam int PRP_MIN_RATE_KSPS = 8;
  localparam int PRP_MCLK_KHZ = 40000;
  // slowest rate code that still meets the pace minimum
  localparam int PRP_PACE_RATE_MAX =
    (PRP_MCLK_KHZ / PRP_MIN_RATE_KSPS) / (2 * PRP_DR_BASE_CYC);

  // host register offsets on the user port
  localparam logic [3:0] PRP_H_CTRL = 4'h0;
  localparam logic [3:0] PRP_H_CFG0 = 4'h1;
  localparam logic [3:0] PRP_H_STATUS = 4'h6;
  localparam logic [3:0] PRP_H_PINS = 4'h7;
  localparam logic [3:0] PRP_H_PEEK_REQ = 4'h8;
  localparam logic [3:0] PRP_H_PEEK_DATA = 4'h9;
  localparam int PRP_CTRL_EN_BIT = 0;
  localparam int PRP_CTRL_PACE_IN_BIT = 1;

endpackage : prp_pkg

// *** tb/prp_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module prp_checker
  import prp_pkg::*;
#(
  parameter int unsigned POR_CYC = PRP_POR_CLK
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_run,
  input wire logic dev_rst_n,
  input wire logic we,
  input wire logic [PRP_AW-1:0] addr,
  input wire logic [PRP_DW-1:0] wdata,
  input wire logic [PRP_DW-1:0] rdata,
  input wire logic drdy,
  input wire logic [PRP_FRAME_W-1:0] frame,
  input wire logic [PRP_PINS-1:0] gpio_dev_out,
  input wire logic [PRP_PINS-1:0] gpio_dev_oe
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic [31:0] por_cnt_r;
  logic [1:0] rdy_cnt_r;
  logic [1:0] mode_r;
  wire logic dev_off = !dev_rst_n || !clk_run;
  wire logic restart = we && (addr == PRP_REG_RATE || addr == PRP_REG_PACE);

  // run length before device reset, drdy count, mirrored mode
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || dev_off) begin
      por_cnt_r <= '0;
      rdy_cnt_r <= '0;
      mode_r <= PRP_RESPIRATION_CONFIG_REGISTER_OFF;
    end else begin
      por_cnt_r <= por_cnt_r + 32'h1;
      if (restart) rdy_cnt_r <= 2'h0;
      else if (drdy && rdy_cnt_r != 2'h3) rdy_cnt_r <= rdy_cnt_r + 2'h1;
      if (we && addr == PRP_REG_RESPIRATION_CONFIG_REGISTER) mode_r <= wdata[1:0];
    end
  end

  sequence s_fall_run;
    clk_run && $fell(dev_rst_n);
  endsequence
  sequence s_low2;
    !dev_rst_n [*2];
  endsequence
  property p_por;
    s_fall_run |-> por_cnt_r >= POR_CYC;
  endproperty
  property p_rst_width;
    s_fall_run |-> s_low2 ##[1:8] dev_rst_n;
  endproperty
  property p_prog;
    $rose(dev_rst_n) && $past(clk_run) |-> ##[0:4] we;
  endproperty
  property p_dev_rst;
    dev_off |=> !drdy && gpio_dev_oe == '0 && rdata == '0;
  endproperty
  property p_drdy;
    drdy |=> !drdy;
  endproperty
  property p_respiration_config_register_on;
    we && !dev_off && addr == PRP_REG_RESPIRATION_CONFIG_REGISTER && wdata[1:0] == PRP_RESPIRATION_CONFIG_REGISTER_EXT
      |-> ##[1:3] gpio_dev_oe[3:1] == 3'h7;
  endproperty
  // three cycles of slack so the registered clocks have taken over
  property p_respiration_config_register_pins;
    mode_r == PRP_RESPIRATION_CONFIG_REGISTER_EXT && $past(mode_r, 3) == PRP_RESPIRATION_CONFIG_REGISTER_EXT
      |-> gpio_dev_oe[3:1] == 3'h7 &&
          gpio_dev_out[1] == (gpio_dev_out[2] ^ gpio_dev_out[3]);
  endproperty
  property p_settle;
    $rose(frame[4]) |-> rdy_cnt_r >= 2'h2;
  endproperty
  // host keeps every device input low while the clock is held off
  property p_idle_low;
    !clk_run |-> !dev_rst_n && !we && addr == '0 && wdata == '0;
  endproperty

  a_por: assert property (p_por) else $error("reset came early");
  a_rst_width: assert property (p_rst_width) else $error("short reset");
  a_prog: assert property (p_prog) else $error("no programming");
  a_dev_rst: assert property (p_dev_rst) else $error("not reset");
  a_drdy: assert property (p_drdy) else $error("drdy too long");
  a_respiration_config_register_on: assert property (p_respiration_config_register_on) else $error("pins not out");
  a_respiration_config_register_pins: assert property (p_respiration_config_register_pins) else $error("bad xor");
  a_settle: assert property (p_settle) else $error("settled early");
  a_idle_low: assert property (p_idle_low)
    else $error("link not idle");
endmodule : prp_checker
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module testbench
  import prp_pkg::*;
;
  // shortened counts keep the run brief
  localparam int DRB = 8;
  localparam int RHB = 4;
  localparam int POR = 16;
  logic mclk_i, rst_n_i, we_i, re_i, supply_ok_i, pace_detect_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic pace_on_o, settled_o, respiration_config_register_active_o, ready_o;
  logic [2:0] odd_o, even_o;
  int n_errors = 0;
  int checked = 0;
  int k, h, d;

  prp_link_if u_prp_link_if ();
  prp_device #(.DR_BASE_CYC(DRB), .RESPIRATION_CONFIG_REGISTER_HALF_BASE(RHB)) u_prp_device (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(u_prp_link_if.dev),
    .pace_on_o(pace_on_o), .pace_out_odd_pin_o(odd_o),
    .pace_out_even_pin_o(even_o), .settled_o(settled_o),
    .respiration_config_register_active_o(respiration_config_register_active_o));
  prp_host #(.POR_CYC(POR), .RST_LOW_CYC(PRP_RST_LOW_CLK)) u_prp_host (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(u_prp_link_if.host),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .supply_ok_i(supply_ok_i),
    .pace_detect_i(pace_detect_i), .ready_o(ready_o));
  prp_checker #(.POR_CYC(POR)) u_prp_checker (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_run(u_prp_link_if.clk_run),
    .dev_rst_n(u_prp_link_if.dev_rst_n), .we(u_prp_link_if.we),
    .addr(u_prp_link_if.addr), .wdata(u_prp_link_if.wdata),
    .rdata(u_prp_link_if.rdata), .drdy(u_prp_link_if.drdy),
    .frame(u_prp_link_if.frame), .gpio_dev_out(u_prp_link_if.gpio_dev_out),
    .gpio_dev_oe(u_prp_link_if.gpio_dev_oe));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= dat;
    we_i <= 1'b1;
    @(posedge mclk_i);
    we_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge mclk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge mclk_i);
    re_i <= 1'b0;
    #1 q = rdata_o;
  endtask : rd
  task automatic peek(input logic [2:0] idx, input logic [7:0] e);
    wr(PRP_H_PEEK_REQ, {13'h0, idx});
    repeat (4) tick();
    rd(PRP_H_PEEK_DATA, v);
    `CHK("peek", e, v[7:0])
  endtask : peek
  // one data period measured between two drdy pulses
  task automatic rate_test(input int r);
    wr(PRP_H_CFG0, {13'h0, r[2:0]});
    repeat (4) tick();
    `CHK("settled_early", 1'b0, settled_o)
    k = 0;
    while (u_prp_link_if.drdy !== 1'b1 && k < 500) begin
      tick();
      k++;
    end
    k = 0;
    do begin
      tick();
      k++;
    end while (u_prp_link_if.drdy !== 1'b1 && k < 500);
    `CHK("period", DRB << r, k)
    repeat (3 * (DRB << r)) tick();
    rd(PRP_H_STATUS, v);
    `CHK("settled", 1'b1, v[8])
  endtask : rate_test
  // high time of pin three and how long pin four lags inside it
  task automatic respiration_config_register_meas(output int half, output int dly);
    half = 0;
    dly = 0;
    k = 0;
    while (u_prp_link_if.gpio_lvl[2] !== 1'b0 && k < 500) begin
      tick();
      k++;
    end
    while (u_prp_link_if.gpio_lvl[2] !== 1'b1 && k < 500) begin
      tick();
      k++;
    end
    while (u_prp_link_if.gpio_lvl[2] === 1'b1 && k < 500) begin
      half++;
      if (u_prp_link_if.gpio_lvl[3] !== 1'b1) dly++;
      tick();
      k++;
    end
  endtask : respiration_config_register_meas
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    we_i = 1'b0;
    re_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0;
    supply_ok_i = 1'b0;
    pace_detect_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    supply_ok_i <= 1'b1;
    wr(PRP_H_CTRL, 16'h0001);
    k = 0;
    while (ready_o !== 1'b1 && k < 300) begin
      tick();
      k++;
    end
    `CHK("ready", 1'b1, ready_o)
    rd(PRP_H_STATUS, v);
    `CHK("state", 3'h4, v[2:0])
    peek(3'h4, 8'h0f);
    $display("test power-up done");
    for (int s = 0; s < 4; s++) begin
      wr(PRP_H_CFG0 + 4'h1, {11'h0, s[1:0], s[1:0], 1'b1});
      repeat (4) tick();
      `CHK("pace_on", 1'b1, pace_on_o)
      `CHK("odd", {s[1:0], 1'b0}, odd_o)
      `CHK("even", {s[1:0], 1'b1}, even_o)
    end
    peek(3'h1, 8'h1f);
    wr(PRP_H_CFG0 + 4'h1, 16'h001e);
    repeat (4) tick();
    `CHK("pace_off", 1'b0, pace_on_o)
    rd(PRP_H_CFG0 + 4'h1, v);
    `CHK("cfg_pace", 16'h001e, v)
    $display("test pace routing done");
    rate_test(0);
    rate_test(1);
    $display("test data rate done");
    for (int f = 0; f < 3; f++) begin
      wr(PRP_H_CFG0 + 4'h3, {8'h0, f[2:0], 5'h0});
      wr(PRP_H_CFG0 + 4'h2, {11'h0, f[2:0] + 3'h1, 2'h1});
      respiration_config_register_meas(h, d);
      respiration_config_register_meas(h, d);
      `CHK("half", RHB << f, h)
      `CHK("lag", (f + 1) << f, d)
      `CHK("respiration_config_register_on", 1'b1, respiration_config_register_active_o)
      `CHK("respiration_config_register_oe", 3'h7, u_prp_link_if.gpio_dev_oe[3:1])
    end
    wr(PRP_H_CFG0 + 4'h2, 16'h0000);
    repeat (4) tick();
    `CHK("respiration_config_register_off", 1'b0, respiration_config_register_active_o)
    `CHK("pins_in", 3'h0, u_prp_link_if.gpio_dev_oe[3:1])
    $display("test respiration done");
    // external detector result travels back in the frame
    wr(PRP_H_CTRL, 16'h0003);
    rd(PRP_H_CTRL, v);
    `CHK("ctrl", 16'h0003, v)
    for (int b = 1; b >= 0; b--) begin
      @(posedge mclk_i);
      pace_detect_i <= b[0];
      repeat (60) tick();
      rd(PRP_H_STATUS, v);
      `CHK("frame_pin", b[0], v[4])
      rd(PRP_H_PINS, v);
      `CHK("pin_one", b[0], v[0])
    end
    $display("test pace detect done");
    tally_and_finish();
  end

  // watchdog: all tests need well under 8000 cycles
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
